// [core/parallel_line_controller.sv]
// Parallel line controller: APB register file, pin ownership mux and input sampling
// ********************************
// Summary of operation
// - Up to 32 lines; line n is bit n of every register.
// - Pull-up on write clears status bit, off write sets it; 1 means off.
// - Pull-up writes act regardless of ownership or direction.
// - Pull-up status resets to zero, all pull-ups active.
// - Own enable sets, own disable clears ownership bit; 1 means controller drives.
// - Unmuxed lines ignore ownership writes and always read ownership 1.
// - Ownership reset value is a per-line build parameter.
// - Select A clears, select B sets function bit; 0 is A, 1 is B.
// - Function select steers outputs only; both peripherals see the pin input.
// - Function select status resets to zero, peripheral A.
// - A/B writes act regardless of ownership; handover needs select and disable.
// - Peripheral-owned line takes enable and value from the selected peripheral.
// - Drive enable sets, drive disable clears direction bit; 1 drives the line.
// - Level set and clear writes steer the level driven by the controller.
// - Drive and level writes update even while a peripheral owns the line.
// - Direct level write updates only bits enabled in the write mask.
// - Write mask resets to zero.
// - Register writes work without the gated line clock.
// - Pin level sampling runs only while the gated line clock runs; the peripheral inputs sample the pins without it.
// - Each line offers a glitch filter rejecting pulses shorter than two cycles.
// - Unimplemented line bits ignore writes and read zero.
// ********************************
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
module parallel_line_controller
	import line_ctrl_pkg::*;
#(
	parameter int LINES = 32,
	parameter logic [31:0] LINES_PRESENT = DEF_LINES_PRESENT,
	parameter logic [31:0] LINES_MUXED = DEF_LINES_MUXED,
	parameter logic [31:0] LINE_OWN_RESET = DEF_LINE_OWN_RESET
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Gated line clock enable from power management
	input wire logic line_clk_on,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral functions
	input periph_out_t periph_a,
	input periph_out_t periph_b,
	output logic [31:0] periph_in,
	// Pins
	input wire logic [31:0] pin_in,
	output pin_drive_t pin
);

	// ********************************
	// Elaboration checks and masks
	// ********************************
	localparam logic [31:0] PRESENT = LINES_PRESENT & ((LINES == 32) ? 32'hffff_ffff : ((32'h1 << LINES) - 32'h1));
	localparam logic [31:0] MUXED = LINES_MUXED & PRESENT;

	// Line count outside one register word
	if (LINES < 1 || LINES > 32)
	begin : bad_lines
		$error("LINES must lie between 1 and 32");
	end

	// No present line inside the line count
	if (PRESENT == 32'h0000_0000)
	begin : no_lines
		$error("no present line within LINES");
	end

	// Unmuxed lines can only reset controller-owned
	if ((~LINE_OWN_RESET & PRESENT & ~MUXED) != 32'h0000_0000)
	begin : bad_own_reset
		$error("unmuxed line cannot reset peripheral-owned");
	end

	// ********************************
	// Register state
	// ********************************
	logic [31:0] pullup_q;
	logic [31:0] own_q;
	logic [31:0] absel_q;
	logic [31:0] drive_q;
	logic [31:0] level_q;
	logic [31:0] wmask_q;
	logic [31:0] filt_q;
	logic [31:0] sync1_q;
	logic [31:0] sync2_q;
	logic [31:0] filt_prev_q;
	logic [31:0] pin_level_q;
	logic [31:0] periph_s1_q;
	logic [31:0] periph_s2_q;
	logic [31:0] agree;
	logic [31:0] pin_level_d;
	pin_drive_t pin_d;
	logic wr_en;
	logic known;
	logic [31:0] wbits;
	logic [31:0] rd_d;

	// Write strobe on access phase
	assign wr_en = psel & penable & pwrite;
	// Unimplemented line bits are dropped
	assign wbits = pwdata & PRESENT;

	// Pull-up status: on clears, off sets
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pullup_q <= RST_PULLUP_STATE;
		else if (wr_en && paddr == OFS_PULLUP_ON_WRITE)
			pullup_q <= pullup_q & ~wbits;
		else if (wr_en && paddr == OFS_PULLUP_OFF_WRITE)
			pullup_q <= pullup_q | wbits;
	end

	// Ownership: only muxed lines can change
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			own_q <= (LINE_OWN_RESET | ~MUXED) & PRESENT;
		else if (wr_en && paddr == OFS_LINE_OWN_ENABLE)
			own_q <= own_q | (wbits & MUXED);
		else if (wr_en && paddr == OFS_LINE_OWN_DISABLE)
			own_q <= own_q & ~(wbits & MUXED);
	end

	// Function select, independent of ownership
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			absel_q <= RST_FUNC_SELECT;
		else if (wr_en && paddr == OFS_FUNC_A_SELECT)
			absel_q <= absel_q & ~(wbits & MUXED);
		else if (wr_en && paddr == OFS_FUNC_B_SELECT)
			absel_q <= absel_q | (wbits & MUXED);
	end

	// Drive direction, updated in any ownership
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drive_q <= RST_DRIVE_STATE;
		else if (wr_en && paddr == OFS_DRIVE_ENABLE_WRITE)
			drive_q <= drive_q | wbits;
		else if (wr_en && paddr == OFS_DRIVE_DISABLE_WRITE)
			drive_q <= drive_q & ~wbits;
	end

	// Driven level: set, clear or masked direct write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_q <= RST_DRIVEN_LEVEL;
		else if (wr_en && paddr == OFS_LEVEL_SET_WRITE)
			level_q <= level_q | wbits;
		else if (wr_en && paddr == OFS_LEVEL_CLEAR_WRITE)
			level_q <= level_q & ~wbits;
		else if (wr_en && paddr == OFS_DRIVEN_LEVEL)
			level_q <= (level_q & ~wmask_q) | (wbits & wmask_q);
	end

	// Direct write mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wmask_q <= RST_WRITE_MASK;
		else if (wr_en && paddr == OFS_DIRECT_WRITE_MASK_ON)
			wmask_q <= wmask_q | wbits;
		else if (wr_en && paddr == OFS_DIRECT_WRITE_MASK_OFF)
			wmask_q <= wmask_q & ~wbits;
	end

	// Glitch filter enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filt_q <= RST_FILTER_STATE;
		else if (wr_en && paddr == OFS_FILTER_ON_WRITE)
			filt_q <= filt_q | wbits;
		else if (wr_en && paddr == OFS_FILTER_OFF_WRITE)
			filt_q <= filt_q & ~wbits;
	end

	// ********************************
	// Input sampling
	// ********************************

	// Two-stage synchroniser, runs only with line clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_q <= 32'h0000_0000;
			sync2_q <= 32'h0000_0000;
		end
		else if (line_clk_on)
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// Peripheral input synchroniser, free of the line clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			periph_s1_q <= 32'h0000_0000;
			periph_s2_q <= 32'h0000_0000;
		end
		else
		begin
			periph_s1_q <= pin_in;
			periph_s2_q <= periph_s1_q;
		end
	end

	// Per-line agreement of the last two samples
	assign agree = ~(sync2_q ^ filt_prev_q);

	// Filtered lines keep their level until two samples agree
	assign pin_level_d = (~filt_q & sync2_q) | (filt_q & agree & sync2_q) | (filt_q & ~agree & pin_level_q);

	// Filter stage; level frozen when the line clock stops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			filt_prev_q <= 32'h0000_0000;
			pin_level_q <= 32'h0000_0000;
		end
		else if (line_clk_on)
		begin
			filt_prev_q <= sync2_q;
			pin_level_q <= pin_level_d;
		end
	end

	// ********************************
	// Register read
	// ********************************

	// Read decode; status registers ignore writes
	always_comb
	begin
		known = 1'b1;
		rd_d = 32'h0000_0000;
		unique case (paddr)
			OFS_PULLUP_STATE: rd_d = pullup_q;
			OFS_LINE_OWN_STATE: rd_d = own_q | (~MUXED & PRESENT);
			OFS_FUNC_SELECT_STATE: rd_d = absel_q;
			OFS_DRIVE_STATE: rd_d = drive_q;
			OFS_DRIVEN_LEVEL: rd_d = level_q;
			OFS_DIRECT_WRITE_MASK: rd_d = wmask_q;
			OFS_FILTER_STATE: rd_d = filt_q;
			OFS_PIN_LEVEL: rd_d = pin_level_q;
			OFS_PULLUP_ON_WRITE, OFS_PULLUP_OFF_WRITE, OFS_LINE_OWN_ENABLE, OFS_LINE_OWN_DISABLE,
			OFS_FUNC_A_SELECT, OFS_FUNC_B_SELECT, OFS_DRIVE_ENABLE_WRITE, OFS_DRIVE_DISABLE_WRITE,
			OFS_LEVEL_SET_WRITE, OFS_LEVEL_CLEAR_WRITE, OFS_DIRECT_WRITE_MASK_ON,
			OFS_DIRECT_WRITE_MASK_OFF, OFS_FILTER_ON_WRITE, OFS_FILTER_OFF_WRITE: rd_d = 32'h0000_0000;
			default: known = 1'b0;
		endcase
		rd_d = rd_d & PRESENT;
	end

	// Registered read data, held until the next setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= pwrite ? 32'h0000_0000 : rd_d;
	end

	// Error stands only beside ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel & ~penable & ~known;
	end

	// Ready follows setup cycle by one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel & ~penable;
	end

	// ********************************
	// Pin and peripheral muxing
	// ********************************

	// Owner mux for each line
	always_comb
	begin
		pin_d = '0;
		for (int i = 0; i < 32; i++)
		begin
			if (!PRESENT[i])
			begin
				pin_d.out_en[i] = 1'b0;
				pin_d.out_val[i] = 1'b0;
			end
			else if (own_q[i])
			begin
				pin_d.out_en[i] = drive_q[i];
				pin_d.out_val[i] = level_q[i];
			end
			else
			begin
				pin_d.out_en[i] = absel_q[i] ? periph_b.drive_en[i] : periph_a.drive_en[i];
				pin_d.out_val[i] = absel_q[i] ? periph_b.level[i] : periph_a.level[i];
			end
		end
		pin_d.pullup_en = ~pullup_q & PRESENT;
	end

	// Registered pin drive and peripheral inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin <= '0;
			periph_in <= 32'h0000_0000;
		end
		else
		begin
			pin <= pin_d;
			periph_in <= periph_s2_q;
		end
	end

endmodule

// [common/line_ctrl_pkg.sv]
// Package: register map and field layouts for the parallel line controller
package line_ctrl_pkg;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] OFS_LINE_OWN_ENABLE = 8'h00;
	localparam logic [7:0] OFS_LINE_OWN_DISABLE = 8'h04;
	localparam logic [7:0] OFS_LINE_OWN_STATE = 8'h08;
	localparam logic [7:0] OFS_DRIVE_ENABLE_WRITE = 8'h10;
	localparam logic [7:0] OFS_DRIVE_DISABLE_WRITE = 8'h14;
	localparam logic [7:0] OFS_DRIVE_STATE = 8'h18;
	localparam logic [7:0] OFS_FILTER_ON_WRITE = 8'h20;
	localparam logic [7:0] OFS_FILTER_OFF_WRITE = 8'h24;
	localparam logic [7:0] OFS_FILTER_STATE = 8'h28;
	localparam logic [7:0] OFS_LEVEL_SET_WRITE = 8'h30;
	localparam logic [7:0] OFS_LEVEL_CLEAR_WRITE = 8'h34;
	localparam logic [7:0] OFS_DRIVEN_LEVEL = 8'h38;
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h3c;
	localparam logic [7:0] OFS_PULLUP_ON_WRITE = 8'h60;
	localparam logic [7:0] OFS_PULLUP_OFF_WRITE = 8'h64;
	localparam logic [7:0] OFS_PULLUP_STATE = 8'h68;
	localparam logic [7:0] OFS_FUNC_A_SELECT = 8'h70;
	localparam logic [7:0] OFS_FUNC_B_SELECT = 8'h74;
	localparam logic [7:0] OFS_FUNC_SELECT_STATE = 8'h78;
	localparam logic [7:0] OFS_DIRECT_WRITE_MASK_ON = 8'ha0;
	localparam logic [7:0] OFS_DIRECT_WRITE_MASK_OFF = 8'ha4;
	localparam logic [7:0] OFS_DIRECT_WRITE_MASK = 8'ha8;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [31:0] RST_PULLUP_STATE = 32'h0000_0000;
	localparam logic [31:0] RST_FUNC_SELECT = 32'h0000_0000;
	localparam logic [31:0] RST_DRIVE_STATE = 32'h0000_0000;
	localparam logic [31:0] RST_DRIVEN_LEVEL = 32'h0000_0000;
	localparam logic [31:0] RST_WRITE_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_FILTER_STATE = 32'h0000_0000;
	localparam logic [31:0] DEF_LINE_OWN_RESET = 32'hffff_ffff;
	localparam logic [31:0] DEF_LINES_PRESENT = 32'hffff_ffff;
	localparam logic [31:0] DEF_LINES_MUXED = 32'hffff_ffff;

	// ********************************
	// Grouped signals
	// ********************************
	typedef struct packed
	{
		logic [31:0] drive_en;
		logic [31:0] level;
	} periph_out_t;

	typedef struct packed
	{
		logic [31:0] out_en;
		logic [31:0] out_val;
		logic [31:0] pullup_en;
	} pin_drive_t;

endpackage

// [bench/line_ctrl_props.sv]
// Checker: port properties of the parallel line controller
module line_ctrl_props
	import line_ctrl_pkg::*;
#(
	parameter logic [31:0] LINES_PRESENT = DEF_LINES_PRESENT
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Lines
	input wire logic [31:0] pin_in,
	input wire logic [31:0] periph_in,
	input pin_drive_t pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********************************
	// Properties
	// ********************************
	logic [1:0] up_q;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Cycles since reset release, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	end
	answer_next_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	err_unmapped_a: assert property (psel && !penable && paddr == 8'hfc |=> pslverr)
		else $error("unmapped access not refused");
	pullup_reset_a: assert property (up_q == 2'h1 |-> (pin.pullup_en & LINES_PRESENT) == LINES_PRESENT)
		else $error("pull-ups not on after reset");
	sync_in_a: assert property (up_q == 2'h3 |-> periph_in == $past(pin_in, 3))
		else $error("peripheral input not the pin level");
	pullup_on_a: assert property (psel && penable && pready && pwrite && paddr == OFS_PULLUP_ON_WRITE
		|-> ##2 (pin.pullup_en & $past(pwdata, 2) & LINES_PRESENT) == ($past(pwdata, 2) & LINES_PRESENT))
		else $error("pull-up on write not applied");
	pullup_off_a: assert property (psel && penable && pready && pwrite && paddr == OFS_PULLUP_OFF_WRITE
		|-> ##2 (pin.pullup_en & $past(pwdata, 2)) == 32'h0)
		else $error("pull-up off write not applied");
	pullup_hold_a: assert property (up_q == 2'h3 && $changed(pin.pullup_en)
		|-> $past(pready && pwrite && (paddr == OFS_PULLUP_ON_WRITE || paddr == OFS_PULLUP_OFF_WRITE), 2))
		else $error("pull-up changed without a pull-up write");
	// Main scenarios
	cover property (pready && pslverr);
	cover property (pready && pwrite && paddr == OFS_DRIVEN_LEVEL);
	cover property ($changed(pin.out_en));
endmodule

// [bench/line_far_side.sv]
// Far-side model: pin resolution and two peripheral functions
module line_far_side
	import line_ctrl_pkg::*;
(
	// Controller drive and external source
	input pin_drive_t pin,
	input wire logic [31:0] ext,
	// Pin levels and peripheral requests
	output logic [31:0] pin_in,
	output periph_out_t periph_a,
	output periph_out_t periph_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// Fixed peripheral drive patterns
	assign periph_a = {32'h5555_5555, 32'h0f0f_0f0f};
	assign periph_b = {32'haaaa_aaaa, 32'h3c3c_3c3c};
	// Driven level first, then pull-up, then external source
	assign pin_in = (pin.out_en & pin.out_val) | (~pin.out_en & (pin.pullup_en | ext));
endmodule

// [bench/tb.sv]
// Testbench: register sequences and pin checks for the parallel line controller
module tb
	import line_ctrl_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	// ********************************
	// Bench
	// ********************************
	localparam logic [31:0] PRES = 32'hbfff_ffff;
	localparam logic [31:0] MUX = 32'h7fff_ffff;
	localparam logic [31:0] OWN_RST = 32'hffff_fff7;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic line_clk_on = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] ext = 32'h0;
	logic [31:0] prdata, periph_in, pin_in, en_m, val_m, lv0;
	logic pready, pslverr;
	periph_out_t periph_a, periph_b;
	pin_drive_t pin;
	logic [31:0] pu_m = 32'h0, fs_m = 32'h0, drv_m = 32'h0, lv_m = 32'h0, wm_m = 32'h0;
	logic [31:0] own_m = OWN_RST | ~MUX;
	int mismatches = 0;
	int cmp_count = 0;
	// Clock of 100 ns
	always #50 pclk = ~pclk;
	parallel_line_controller #(.LINES_PRESENT(PRES), .LINES_MUXED(MUX), .LINE_OWN_RESET(OWN_RST))
		u_parallel_line_controller (.pclk, .presetn, .line_clk_on, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .periph_a, .periph_b, .periph_in, .pin_in, .pin);
	line_far_side u_line_far_side (.pin, .ext, .pin_in, .periph_a, .periph_b);
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer, ready awaited under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
		begin
			mismatches++;
			end_sim();
		end
		rd = prdata;
		chk({31'h0, pslverr}, {31'h0, a == 8'hfc});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Write and update the register mirror
	task automatic wrm(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		apb(1'b1, a, d, rd);
		case (a)
			OFS_PULLUP_ON_WRITE: pu_m &= ~d;
			OFS_PULLUP_OFF_WRITE: pu_m |= d;
			OFS_LINE_OWN_ENABLE: own_m |= d;
			OFS_LINE_OWN_DISABLE: own_m &= ~(d & MUX);
			OFS_FUNC_A_SELECT: fs_m &= ~d;
			OFS_FUNC_B_SELECT: fs_m |= d & MUX;
			OFS_DRIVE_ENABLE_WRITE: drv_m |= d;
			OFS_DRIVE_DISABLE_WRITE: drv_m &= ~d;
			OFS_LEVEL_SET_WRITE: lv_m |= d;
			OFS_LEVEL_CLEAR_WRITE: lv_m &= ~d;
			OFS_DRIVEN_LEVEL: lv_m = (lv_m & ~wm_m) | (d & wm_m);
			OFS_DIRECT_WRITE_MASK_ON: wm_m |= d;
			OFS_DIRECT_WRITE_MASK_OFF: wm_m &= ~d;
			default: ;
		endcase
	endtask
	// Status reads and pin drive against the mirror
	task automatic verify();
		logic [31:0] rd;
		logic [7:0] ad [6] = '{OFS_PULLUP_STATE, OFS_LINE_OWN_STATE, OFS_FUNC_SELECT_STATE,
			OFS_DRIVE_STATE, OFS_DRIVEN_LEVEL, OFS_DIRECT_WRITE_MASK};
		logic [31:0] ex [6] = '{pu_m, own_m, fs_m, drv_m, lv_m, wm_m};
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, ad[i], 32'h0, rd);
			chk(rd, ex[i] & PRES);
		end
		en_m = (own_m & drv_m) | (~own_m & ((fs_m & periph_b.drive_en) | (~fs_m & periph_a.drive_en)));
		val_m = (own_m & lv_m) | (~own_m & ((fs_m & periph_b.level) | (~fs_m & periph_a.level)));
		chk(pin.out_en, en_m & PRES);
		chk(pin.out_val & en_m & PRES, val_m & en_m & PRES);
		chk(pin.pullup_en, ~pu_m & PRES);
	endtask
	// Pin level read after the input has settled
	task automatic lvl_chk(input logic [31:0] exp);
		logic [31:0] rd;
		repeat (6) @(posedge pclk);
		apb(1'b0, OFS_PIN_LEVEL, 32'h0, rd);
		chk(rd, exp & PRES);
	endtask
	// Main sequence, configured with the line clock stopped
	initial
	begin
		logic [39:0] seq [18] = '{{OFS_PULLUP_OFF_WRITE, 32'h00f0_00f0}, {OFS_PULLUP_ON_WRITE, 32'h0000_00f0},
			{OFS_PULLUP_STATE, 32'hffff_ffff}, {OFS_LINE_OWN_DISABLE, 32'h0fff_0000},
			{OFS_FUNC_B_SELECT, 32'h00f0_0000}, {OFS_FUNC_A_SELECT, 32'h0030_0000},
			{OFS_DRIVE_ENABLE_WRITE, 32'h0f00_00ff}, {OFS_LEVEL_SET_WRITE, 32'h0f00_000f},
			{OFS_LEVEL_CLEAR_WRITE, 32'h0000_0003}, {OFS_DIRECT_WRITE_MASK_ON, 32'h0000_00f0},
			{OFS_DRIVEN_LEVEL, 32'hffff_ffff}, {OFS_DIRECT_WRITE_MASK_OFF, 32'h0000_0030},
			{OFS_DRIVEN_LEVEL, 32'h0}, {OFS_LINE_OWN_DISABLE, 32'hffff_ffff}, {8'hfc, 32'hffff_ffff},
			{OFS_LINE_OWN_ENABLE, 32'h0f00_0008}, {OFS_DRIVE_DISABLE_WRITE, 32'h0000_0081},
			{OFS_FUNC_B_SELECT, 32'hffff_ffff}};
		logic [31:0] rd;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		verify();
		foreach (seq[i])
		begin
			wrm(seq[i][39:32], seq[i][31:0]);
			verify();
		end
		lv0 = (en_m & val_m) | (~en_m & (~pu_m | ext));
		line_clk_on <= 1'b1;
		lvl_chk(lv0);
		line_clk_on <= 1'b0;
		@(posedge pclk);
		ext <= 32'hffff_ffff;
		lvl_chk(lv0);
		line_clk_on <= 1'b1;
		lvl_chk((en_m & val_m) | ~en_m);
		// Filter on every line, then a one-cycle low pulse
		wrm(OFS_FILTER_ON_WRITE, 32'hffff_ffff);
		apb(1'b0, OFS_FILTER_STATE, 32'h0, rd);
		chk(rd, PRES);
		ext <= 32'h0000_0000;
		@(posedge pclk);
		ext <= 32'hffff_ffff;
		repeat (2) @(posedge pclk);
		apb(1'b0, OFS_PIN_LEVEL, 32'h0, rd);
		chk(rd, ((en_m & val_m) | ~en_m) & PRES);
		// A lasting change passes the filter
		ext <= 32'h0000_0000;
		lvl_chk((en_m & val_m) | (~en_m & ~pu_m));
		end_sim();
	end
endmodule
bind parallel_line_controller line_ctrl_props #(.LINES_PRESENT(LINES_PRESENT)) u_line_ctrl_props (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .pin_in, .periph_in, .pin);
